//--- pkg/bbc_pkg.sv
/*
 * Constants, register map and carrier types of the bit-branch and CPU-control
 * execution slice.
 * Assumes one 10 MHz clock and an APB register port with 32-bit data.
 */
package bbc_pkg;
    // Register byte addresses
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_INSTR   = 8'h04;
    localparam logic [7:0] OFS_OPERAND = 8'h08;
    localparam logic [7:0] OFS_PC      = 8'h0c;
    localparam logic [7:0] OFS_PSW     = 8'h10;
    localparam logic [7:0] OFS_RESULT  = 8'h14;
    localparam logic [7:0] OFS_STATUS  = 8'h18;
    // Control bits
    localparam int CTRL_GO   = 0;
    localparam int CTRL_WAKE = 1;
    // Status word field positions
    localparam int PSW_IE = 7, PSW_Z = 6, PSW_RBS1 = 5, PSW_AC = 4, PSW_RBS0 = 3, PSW_CY = 0;
    // Values after reset
    localparam logic [15:0] PC_RST  = 16'h0000;
    localparam logic [7:0]  PSW_RST = 8'h02;
    // Byte lengths
    localparam logic [2:0] LEN_1 = 3'h1, LEN_2 = 3'h2, LEN_3 = 3'h3, LEN_4 = 3'h4;
    // Clock counts, internal high-speed RAM column and other-area column
    localparam logic [7:0] CLK_2 = 8'h02, CLK_4 = 8'h04, CLK_6 = 8'h06, CLK_8 = 8'h08;
    localparam logic [7:0] CLK_9 = 8'h09, CLK_10 = 8'h0a, CLK_11 = 8'h0b, CLK_12 = 8'h0c;
    // Extra clocks when fetching from other than internal program ROM
    localparam logic [7:0] CLK_FETCH_EXT = 8'h02;

    typedef enum logic [3:0] {
        BBC_OP_BIT_SET, BBC_OP_BIT_CLEAR, BBC_OP_BIT_CLR_BR, BBC_OP_DEC_BR,
        BBC_OP_BANK, BBC_OP_NOP, BBC_OP_INT_ALLOW, BBC_OP_INT_BLOCK,
        BBC_OP_HALT, BBC_OP_STOP
    } bbc_op_t;

    typedef enum logic [2:0] {
        BBC_FORM_SADDR, BBC_FORM_SFR, BBC_FORM_ACC, BBC_FORM_PSW,
        BBC_FORM_PTR, BBC_FORM_REG_B, BBC_FORM_REG_C
    } bbc_form_t;

    // Layout of the instruction register
    typedef struct packed {
        logic [3:0] rsv;
        logic       fetch_ext;
        logic       area_ext;
        logic [3:0] m_wait;
        logic [3:0] n_wait;
        logic [7:0] offset;
        logic [2:0] bit_sel;
        bbc_form_t  form;
        bbc_op_t    op;
    } bbc_instr_t;
endpackage : bbc_pkg

//--- hw/bbc_exec.sv
/*
 * Execution unit for bit-test branches, decrement loops and CPU control,
 * reached over APB. Software loads an instruction, its operand byte, PC and
 * status word, then starts it; results and clock count read back afterwards.
 * Assumes an APB master on pclk and that software waits for busy to drop.
 */
`timescale 1ns/1ps
module bbc_exec (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             int_enable,
    output logic      [1:0]  bank_select,
    output logic             clock_pause,
    output logic             deep_sleep
);
    typedef enum logic [1:0] {BBC_IDLE, BBC_EXEC, BBC_STANDBY} bbc_state_t;

    bbc_state_t          state_r;
    bbc_pkg::bbc_instr_t instr_r;
    logic [7:0]          operand_r;
    logic [15:0]         pc_r;
    logic [7:0]          psw_r;
    logic [7:0]          wb_r;
    logic                wb_valid_r;
    logic                taken_r;
    logic [7:0]          clk_last_r;
    logic [7:0]          count_r;
    logic                pause_r;
    logic                sleep_r;
    logic [31:0]         prdata_r;
    logic                pready_r;
    logic                pslverr_r;

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, registered answer
    logic       acc_en;
    logic       wr_en;
    logic       mapped;
    logic       start;
    logic       wake;
    logic [31:0] rd_mux;

    assign acc_en = psel && penable && pready_r;
    assign wr_en  = acc_en && pwrite;
    assign mapped = (paddr <= bbc_pkg::OFS_STATUS) && (paddr[1:0] == 2'b00);
    assign start  = wr_en && (paddr == bbc_pkg::OFS_CTRL) && pwdata[bbc_pkg::CTRL_GO] && (state_r == BBC_IDLE);
    assign wake   = wr_en && (paddr == bbc_pkg::OFS_CTRL) && pwdata[bbc_pkg::CTRL_WAKE] && (state_r == BBC_STANDBY);

    always_comb begin
        case (paddr)
            bbc_pkg::OFS_INSTR:   rd_mux = instr_r;
            bbc_pkg::OFS_OPERAND: rd_mux = {24'h000000, operand_r};
            bbc_pkg::OFS_PC:      rd_mux = {16'h0000, pc_r};
            bbc_pkg::OFS_PSW:     rd_mux = {24'h000000, psw_r};
            bbc_pkg::OFS_RESULT:  rd_mux = {22'h000000, taken_r, wb_valid_r, wb_r};
            bbc_pkg::OFS_STATUS:  rd_mux = {16'h0000, clk_last_r, 5'h00, sleep_r, pause_r, state_r == BBC_EXEC};
            default:              rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= psel && penable && !pready_r;
            if (psel && penable && !pready_r) begin
                prdata_r  <= pwrite ? 32'h00000000 : rd_mux;
                pslverr_r <= !mapped;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Instruction evaluation
    logic [7:0]  tested;
    logic        bit_v;
    logic [7:0]  cleared;
    logic [7:0]  dec;
    logic [2:0]  len;
    logic [7:0]  base_clk;
    logic [7:0]  clocks;
    logic        taken;
    logic        wb_valid;
    logic [7:0]  wb_val;
    logic [7:0]  psw_n;
    logic [15:0] pc_n;
    logic        ext;

    always_comb begin
        tested   = (instr_r.form == bbc_pkg::BBC_FORM_PSW) ? psw_r : operand_r;
        bit_v    = tested[instr_r.bit_sel];
        cleared  = tested & ~(8'h01 << instr_r.bit_sel);
        dec      = operand_r - 8'h01;
        ext      = instr_r.area_ext;
        len      = bbc_pkg::LEN_2;
        base_clk = bbc_pkg::CLK_6;
        taken    = 1'b0;
        wb_valid = 1'b0;
        wb_val   = operand_r;
        psw_n    = psw_r;
        case (instr_r.op)
            bbc_pkg::BBC_OP_BIT_SET: begin
                taken = bit_v;
                case (instr_r.form)
                    bbc_pkg::BBC_FORM_SADDR: begin len = bbc_pkg::LEN_3; base_clk = ext ? bbc_pkg::CLK_9 : bbc_pkg::CLK_8; end
                    bbc_pkg::BBC_FORM_SFR:   begin len = bbc_pkg::LEN_4; base_clk = bbc_pkg::CLK_11; end
                    bbc_pkg::BBC_FORM_PSW:   begin len = bbc_pkg::LEN_3; base_clk = bbc_pkg::CLK_9; end
                    bbc_pkg::BBC_FORM_PTR:   begin len = bbc_pkg::LEN_3; base_clk = ext ? bbc_pkg::CLK_11 : bbc_pkg::CLK_10; end
                    default:                 begin len = bbc_pkg::LEN_3; base_clk = bbc_pkg::CLK_8; end
                endcase
            end
            bbc_pkg::BBC_OP_BIT_CLEAR: begin
                taken = !bit_v;
                case (instr_r.form)
                    bbc_pkg::BBC_FORM_SADDR: begin len = bbc_pkg::LEN_4; base_clk = ext ? bbc_pkg::CLK_11 : bbc_pkg::CLK_10; end
                    bbc_pkg::BBC_FORM_SFR:   begin len = bbc_pkg::LEN_4; base_clk = bbc_pkg::CLK_11; end
                    bbc_pkg::BBC_FORM_PSW:   begin len = bbc_pkg::LEN_4; base_clk = bbc_pkg::CLK_11; end
                    bbc_pkg::BBC_FORM_PTR:   begin len = bbc_pkg::LEN_3; base_clk = ext ? bbc_pkg::CLK_11 : bbc_pkg::CLK_10; end
                    default:                 begin len = bbc_pkg::LEN_3; base_clk = bbc_pkg::CLK_8; end
                endcase
            end
            bbc_pkg::BBC_OP_BIT_CLR_BR: begin
                taken = bit_v;
                case (instr_r.form)
                    bbc_pkg::BBC_FORM_SADDR: begin len = bbc_pkg::LEN_4; base_clk = ext ? bbc_pkg::CLK_12 : bbc_pkg::CLK_10; end
                    bbc_pkg::BBC_FORM_SFR:   begin len = bbc_pkg::LEN_4; base_clk = bbc_pkg::CLK_12; end
                    bbc_pkg::BBC_FORM_PSW:   begin len = bbc_pkg::LEN_4; base_clk = bbc_pkg::CLK_12; end
                    bbc_pkg::BBC_FORM_PTR:   begin len = bbc_pkg::LEN_3; base_clk = ext ? bbc_pkg::CLK_12 : bbc_pkg::CLK_10; end
                    default:                 begin len = bbc_pkg::LEN_3; base_clk = bbc_pkg::CLK_8; end
                endcase
                // Clearing a status word bit can hit the flags themselves
                if (instr_r.form == bbc_pkg::BBC_FORM_PSW) begin
                    psw_n = bit_v ? cleared : psw_r;
                end else begin
                    wb_valid = bit_v;
                    wb_val   = cleared;
                end
            end
            bbc_pkg::BBC_OP_DEC_BR: begin
                wb_valid = 1'b1;
                wb_val   = dec;
                taken    = (dec != 8'h00);
                if (instr_r.form == bbc_pkg::BBC_FORM_SADDR) begin
                    len      = bbc_pkg::LEN_3;
                    base_clk = ext ? bbc_pkg::CLK_10 : bbc_pkg::CLK_8;
                end
            end
            bbc_pkg::BBC_OP_BANK: begin
                base_clk = bbc_pkg::CLK_4;
                psw_n[bbc_pkg::PSW_RBS1] = instr_r.bit_sel[1];
                psw_n[bbc_pkg::PSW_RBS0] = instr_r.bit_sel[0];
            end
            bbc_pkg::BBC_OP_NOP: begin
                len      = bbc_pkg::LEN_1;
                base_clk = bbc_pkg::CLK_2;
            end
            bbc_pkg::BBC_OP_INT_ALLOW: psw_n[bbc_pkg::PSW_IE] = 1'b1;
            bbc_pkg::BBC_OP_INT_BLOCK: psw_n[bbc_pkg::PSW_IE] = 1'b0;
            default: ;
        endcase
        clocks = base_clk + (instr_r.form == bbc_pkg::BBC_FORM_PTR && ext ? {4'h0, instr_r.n_wait} : 8'h00)
               + (instr_r.op == bbc_pkg::BBC_OP_BIT_CLR_BR && instr_r.form == bbc_pkg::BBC_FORM_PTR && ext
                  ? {4'h0, instr_r.m_wait} : 8'h00)
               + (instr_r.fetch_ext ? bbc_pkg::CLK_FETCH_EXT : 8'h00);
        // Offset taken from the address of the next instruction
        pc_n = pc_r + {13'h0000, len} + (taken ? {{8{instr_r.offset[7]}}, instr_r.offset} : 16'h0000);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Architectural state; results commit on the start write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_r   <= '0;
            operand_r <= 8'h00;
        end else if (wr_en && state_r == BBC_IDLE) begin
            if (paddr == bbc_pkg::OFS_INSTR)   instr_r   <= bbc_pkg::bbc_instr_t'(pwdata);
            if (paddr == bbc_pkg::OFS_OPERAND) operand_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_r  <= bbc_pkg::PC_RST;
            psw_r <= bbc_pkg::PSW_RST;
        end else if (start) begin
            pc_r  <= pc_n;
            psw_r <= psw_n;
        end else if (wr_en && state_r == BBC_IDLE) begin
            if (paddr == bbc_pkg::OFS_PC)  pc_r  <= pwdata[15:0];
            if (paddr == bbc_pkg::OFS_PSW) psw_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wb_r       <= 8'h00;
            wb_valid_r <= 1'b0;
            taken_r    <= 1'b0;
            clk_last_r <= 8'h00;
        end else if (start) begin
            wb_r       <= wb_val;
            wb_valid_r <= wb_valid;
            taken_r    <= taken;
            clk_last_r <= clocks;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: busy for the instruction's clock count, then idle or standby
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= BBC_IDLE;
            count_r <= 8'h00;
            pause_r <= 1'b0;
            sleep_r <= 1'b0;
        end else begin
            case (state_r)
                BBC_IDLE: if (start) begin
                    state_r <= BBC_EXEC;
                    count_r <= clocks - 8'h01;
                    pause_r <= (instr_r.op == bbc_pkg::BBC_OP_HALT);
                    sleep_r <= (instr_r.op == bbc_pkg::BBC_OP_STOP);
                end
                BBC_EXEC: begin
                    count_r <= count_r - 8'h01;
                    if (count_r == 8'h00) state_r <= (pause_r || sleep_r) ? BBC_STANDBY : BBC_IDLE;
                end
                BBC_STANDBY: if (wake) begin
                    state_r <= BBC_IDLE;
                    pause_r <= 1'b0;
                    sleep_r <= 1'b0;
                end
                default: state_r <= BBC_IDLE;
            endcase
        end
    end

    assign prdata      = prdata_r;
    assign pready      = pready_r;
    assign pslverr     = pslverr_r;
    assign int_enable  = psw_r[bbc_pkg::PSW_IE];
    assign bank_select = {psw_r[bbc_pkg::PSW_RBS1], psw_r[bbc_pkg::PSW_RBS0]};
    assign clock_pause = pause_r;
    assign deep_sleep  = sleep_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic st_set, st_clr, st_bcl, st_dec;
    assign st_set = start && instr_r.op == bbc_pkg::BBC_OP_BIT_SET;
    assign st_clr = start && instr_r.op == bbc_pkg::BBC_OP_BIT_CLEAR;
    assign st_bcl = start && instr_r.op == bbc_pkg::BBC_OP_BIT_CLR_BR;
    assign st_dec = start && instr_r.op == bbc_pkg::BBC_OP_DEC_BR;

    a_set_saddr_pc: assert property (st_set && instr_r.form == bbc_pkg::BBC_FORM_SADDR
        |=> pc_r == $past(pc_r) + 16'h0003 + ($past(bit_v) ? {{8{$past(instr_r.offset[7])}}, $past(instr_r.offset)} : 16'h0000))
        else $error("bit-set branch PC wrong");
    a_clear_saddr_pc: assert property (st_clr && instr_r.form == bbc_pkg::BBC_FORM_SADDR && !bit_v
        |=> pc_r == $past(pc_r) + 16'h0004 + {{8{$past(instr_r.offset[7])}}, $past(instr_r.offset)})
        else $error("bit-clear branch PC wrong");
    a_clr_br_write: assert property (st_bcl && bit_v && instr_r.form != bbc_pkg::BBC_FORM_PSW
        |=> wb_valid_r && taken_r && wb_r[$past(instr_r.bit_sel)] == 1'b0)
        else $error("branch-and-clear did not clear bit");
    a_flags_kept: assert property (start
        && !(instr_r.op == bbc_pkg::BBC_OP_BIT_CLR_BR && instr_r.form == bbc_pkg::BBC_FORM_PSW)
        |=> {psw_r[bbc_pkg::PSW_Z], psw_r[bbc_pkg::PSW_AC], psw_r[bbc_pkg::PSW_CY]}
            == $past({psw_r[bbc_pkg::PSW_Z], psw_r[bbc_pkg::PSW_AC], psw_r[bbc_pkg::PSW_CY]}))
        else $error("flags changed unexpectedly");
    a_dec_value: assert property (st_dec |=> wb_r == $past(operand_r) - 8'h01 && taken_r == (wb_r != 8'h00))
        else $error("decrement branch wrong");
    a_int_allow: assert property (start && instr_r.op == bbc_pkg::BBC_OP_INT_ALLOW |=> int_enable)
        else $error("interrupt enable not set");
    a_int_block: assert property (start && instr_r.op == bbc_pkg::BBC_OP_INT_BLOCK |=> !int_enable)
        else $error("interrupt enable not cleared");
    a_saddr_clocks: assert property (st_set && instr_r.form == bbc_pkg::BBC_FORM_SADDR && !ext && !instr_r.fetch_ext
        |=> clk_last_r == 8'h08 ##0 (state_r == BBC_EXEC) [*8] ##1 state_r != BBC_EXEC)
        else $error("short direct test not 8 clocks");
    a_sfr_clocks: assert property (st_bcl && instr_r.form == bbc_pkg::BBC_FORM_SFR && !instr_r.fetch_ext
        |=> clk_last_r == 8'h0c)
        else $error("register clear branch not 12 clocks");
    a_ptr_read_wait: assert property ((st_set || st_clr) && instr_r.form == bbc_pkg::BBC_FORM_PTR && ext && !instr_r.fetch_ext
        |=> clk_last_r == 8'h0b + {4'h0, $past(instr_r.n_wait)})
        else $error("pointer read clocks wrong");
    a_ptr_rw_wait: assert property (st_bcl && instr_r.form == bbc_pkg::BBC_FORM_PTR && ext && !instr_r.fetch_ext
        |=> clk_last_r == 8'h0c + {4'h0, $past(instr_r.n_wait)} + {4'h0, $past(instr_r.m_wait)})
        else $error("pointer read-write clocks wrong");
    a_bank_write: assert property (start && instr_r.op == bbc_pkg::BBC_OP_BANK |=> bank_select == $past(instr_r.bit_sel[1:0]))
        else $error("bank select not written");
    a_halt_pause: assert property (start && instr_r.op == bbc_pkg::BBC_OP_HALT |=> clock_pause && !deep_sleep)
        else $error("halt did not pause");

    c_branch_taken: cover property (st_set && bit_v);
    c_dec_loop_end: cover property (st_dec && operand_r == 8'h01);
    c_stop_wake: cover property (deep_sleep ##[1:40] wake);
endmodule : bbc_exec

//--- tb/bbc_apb_master.sv
/* APB master model standing in front of the execution unit's register port.
   Assumes the bench calls xfer from one process at a time, clocked by pclk. */
`timescale 1ns/1ps
module bbc_apb_master (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Waits for pready as long as it takes; only the bench watchdog ends a hang
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : bbc_apb_master

//--- tb/tb_bit_branch_cpu_control_exec.sv
/* Self-checking bench for the bit-branch and CPU-control execution unit.
   Assumes the APB master model beside it and a 10 MHz pclk. */
`timescale 1ns/1ps
module tb_bit_branch_cpu_control_exec;
    typedef struct packed {
        logic [31:0] instr;
        logic [7:0]  opnd;
        logic [7:0]  program_status_word;
        logic [15:0] pc;
        logic [15:0] epc;
        logic [7:0]  epsw;
        logic [9:0]  eres;
        logic [9:0]  rmask;
        logic [7:0]  eclk;
    } bbc_row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        int_enable, clock_pause, deep_sleep;
    logic [1:0]  bank_select;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, keep;
    int          fail_count, total_checks;
    bbc_row_t    rows [16];
    bbc_row_t    r;
    initial pclk = 1'b0;
    always #50 pclk = ~pclk;
    bbc_exec bbc_exec_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .int_enable(int_enable), .bank_select(bank_select), .clock_pause(clock_pause), .deep_sleep(deep_sleep));
    bbc_apb_master bbc_apb_master_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] mk(input int op, fm, b, off, n, m, ar, fe);
        return {4'h0, fe[0], ar[0], m[3:0], n[3:0], off[7:0], b[2:0], fm[2:0], op[3:0]};
    endfunction : mk
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bbc_apb_master_i.xfer(1'b1, a, d, rd, err);
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        bbc_apb_master_i.xfer(1'b0, a, 32'h0, rd, err);
    endtask : rdr
    // Leaves the last STATUS register read in rd
    task automatic go;
        int n;
        wr(bbc_pkg::OFS_PC, {16'h0, r.pc});
        wr(bbc_pkg::OFS_PSW, {24'h0, r.program_status_word});
        wr(bbc_pkg::OFS_OPERAND, {24'h0, r.opnd});
        wr(bbc_pkg::OFS_INSTR, r.instr);
        wr(bbc_pkg::OFS_CTRL, 32'h1);
        n = 0;
        rd = 32'h1;
        while (rd[0] !== 1'b0 && n < 100) begin
            rdr(bbc_pkg::OFS_STATUS);
            n++;
        end
        check("busy", {31'h0, rd[0]}, 32'h0);
    endtask : go
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        stop_test();
    end
    initial begin
        fail_count = 0;
        total_checks = 0;
        presetn = 1'b0;
        // Op and form codes as the instruction register encodes them
        rows[0]  = '{mk(0, 0, 3, 16, 0, 0, 0, 0), 8'h08, 8'h02, 16'h0100, 16'h0113, 8'h02, 10'h200, 10'h300, 8'h08};
        rows[1]  = '{mk(0, 1, 3, 16, 0, 0, 0, 0), 8'hf7, 8'h02, 16'h0100, 16'h0104, 8'h02, 10'h000, 10'h300, 8'h0b};
        rows[2]  = '{mk(1, 0, 0, 128, 0, 0, 1, 0), 8'hfe, 8'h02, 16'h0200, 16'h0184, 8'h02, 10'h200, 10'h300, 8'h0b};
        rows[3]  = '{mk(1, 4, 0, 16, 5, 0, 1, 0), 8'h01, 8'h02, 16'h0200, 16'h0203, 8'h02, 10'h000, 10'h300, 8'h10};
        rows[4]  = '{mk(2, 4, 7, 127, 3, 2, 1, 0), 8'h80, 8'h02, 16'h1000, 16'h1082, 8'h02, 10'h300, 10'h3ff, 8'h11};
        rows[5]  = '{mk(2, 3, 0, 5, 0, 0, 0, 0), 8'h00, 8'h51, 16'h0010, 16'h0019, 8'h50, 10'h200, 10'h200, 8'h0c};
        rows[6]  = '{mk(3, 5, 0, 16, 0, 0, 0, 0), 8'h01, 8'h02, 16'h0030, 16'h0032, 8'h02, 10'h100, 10'h3ff, 8'h06};
        rows[7]  = '{mk(3, 0, 0, 254, 0, 0, 0, 0), 8'h00, 8'h02, 16'h0300, 16'h0301, 8'h02, 10'h3ff, 10'h3ff, 8'h08};
        rows[8]  = '{mk(3, 0, 0, 0, 0, 0, 1, 1), 8'h05, 8'h02, 16'h0400, 16'h0403, 8'h02, 10'h304, 10'h3ff, 8'h0c};
        rows[9]  = '{mk(4, 0, 3, 0, 0, 0, 0, 0), 8'h00, 8'h02, 16'h0050, 16'h0052, 8'h2a, 10'h000, 10'h200, 8'h04};
        rows[10] = '{mk(5, 0, 0, 0, 0, 0, 0, 0), 8'h00, 8'hff, 16'hfffe, 16'hffff, 8'hff, 10'h000, 10'h200, 8'h02};
        rows[11] = '{mk(6, 0, 0, 0, 0, 0, 0, 0), 8'h00, 8'h02, 16'h0060, 16'h0062, 8'h82, 10'h000, 10'h200, 8'h06};
        rows[12] = '{mk(7, 0, 0, 0, 0, 0, 0, 0), 8'h00, 8'hff, 16'h0070, 16'h0072, 8'h7f, 10'h000, 10'h200, 8'h06};
        rows[13] = '{mk(2, 1, 2, 16, 0, 0, 0, 0), 8'h04, 8'h02, 16'h0500, 16'h0514, 8'h02, 10'h300, 10'h3ff, 8'h0c};
        rows[14] = '{mk(0, 2, 1, 240, 0, 0, 0, 0), 8'h02, 8'h02, 16'h0600, 16'h05f3, 8'h02, 10'h200, 10'h300, 8'h08};
        rows[15] = '{mk(3, 6, 0, 4, 0, 0, 0, 0), 8'h03, 8'h02, 16'h0700, 16'h0706, 8'h02, 10'h302, 10'h3ff, 8'h06};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            r = rows[i];
            go();
            check("clocks", {24'h0, rd[15:8]}, {24'h0, r.eclk});
            rdr(bbc_pkg::OFS_PC);
            check("pc", rd, {16'h0, r.epc});
            rdr(bbc_pkg::OFS_PSW);
            check("psw", rd, {24'h0, r.epsw});
            rdr(bbc_pkg::OFS_RESULT);
            check("result", {22'h0, rd[9:0] & r.rmask}, {22'h0, r.eres});
            check("pins", {29'h0, int_enable, bank_select}, {29'h0, r.epsw[7], r.epsw[5], r.epsw[3]});
            $display("row %0d done", i);
        end
        // Halt then stop; a PC write while parked must be refused
        for (int k = 0; k < 2; k++) begin
            r = '{mk(8 + k, 0, 0, 0, 0, 0, 0, 0), 8'h00, 8'ha8, 16'h0080, 16'h0082, 8'ha8, 10'h000, 10'h000, 8'h06};
            go();
            check("standby", {28'h0, rd[2:1], clock_pause, deep_sleep}, k ? 32'h00000009 : 32'h00000006);
            check("clocks", {24'h0, rd[15:8]}, 32'h00000006);
            wr(bbc_pkg::OFS_PC, 32'h00001234);
            rdr(bbc_pkg::OFS_PC);
            check("pc parked", rd, 32'h00000082);
            wr(bbc_pkg::OFS_CTRL, 32'h00000002);
            rdr(bbc_pkg::OFS_STATUS);
            check("wake", {29'h0, rd[2:1], clock_pause | deep_sleep}, 32'h0);
            $display("standby %0d done", k);
        end
        rdr(8'h1c);
        check("unmapped", {31'h0, err}, 32'h1);
        rdr(8'h06);
        check("unaligned", {31'h0, err}, 32'h1);
        rdr(bbc_pkg::OFS_RESULT);
        keep = rd;
        wr(bbc_pkg::OFS_RESULT, 32'hffffffff);
        rdr(bbc_pkg::OFS_RESULT);
        check("result ro", rd, keep);
        $display("refusals done");
        // Second reset in mid-run, with IE and both bank bits still set
        presetn <= 1'b0;
        @(posedge pclk);
        check("reset pins", {27'h0, int_enable, bank_select, clock_pause, deep_sleep}, 32'h0);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdr(bbc_pkg::OFS_PC);
        check("pc reset", rd, {16'h0, bbc_pkg::PC_RST});
        rdr(bbc_pkg::OFS_PSW);
        check("psw reset", rd, {24'h0, bbc_pkg::PSW_RST});
        $display("reset done");
        stop_test();
    end
endmodule : tb_bit_branch_cpu_control_exec
